// ===== ram_io_timer_cfg.svh
// Purpose: constants for the ram, port and interval timer block
// Assumes: included by bare name from the ram, timer and top design files
// Notes:   offsets here are address bit positions and register selectors
`ifndef RAM_IO_TIMER_CFG_SVH
`define RAM_IO_TIMER_CFG_SVH

// bus widths and memory size
`define RIO_ADDR_W        7
`define RIO_DATA_W        8
`define RIO_RAM_DEPTH     128

// address bit positions used by the decoder
`define RIO_A_EDGE_POL    0
`define RIO_A_EDGE_EN     1
`define RIO_A_PORT_SEL    2
`define RIO_A_TMR_IRQ_EN  3
`define RIO_A_TMR_WRITE   4
`define RIO_A_FLAG_SEL    0

// port register selectors on address bits 1:0
`define RIO_PREG_OUT_A    2'h0
`define RIO_PREG_DIR_A    2'h1
`define RIO_PREG_OUT_B    2'h2
`define RIO_PREG_DIR_B    2'h3

// interrupt flag register layout
`define RIO_FLAG_TIMER_BIT 7
`define RIO_FLAG_EDGE_BIT  6
`define RIO_FLAG_LOW_ZERO  6'h00
// reset values
`define RIO_PORT_RESET    8'h00
`define RIO_EDGE_POL_RST  1'b0
`define RIO_EDGE_EN_RST   1'b0
`define RIO_TMR_EN_RST    1'b0
`define RIO_TMR_CNT_RST   8'h00
// prescale: divide by 1, 8, 64, 1024 clocks, held as log2 of the divisor
`define RIO_PRESC_W       10
`define RIO_PRESC_SH_1    4'h0
`define RIO_PRESC_SH_8    4'h3
`define RIO_PRESC_SH_64   4'h6
`define RIO_PRESC_SH_1024 4'hA
`endif

// ===== rio_pkg.sv
// Purpose: shared types of the ram, port and interval timer block
// Assumes: nothing beyond the cfg header
// Notes:   access kinds are one-hot so a stray decode shows up at once
package rio_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [1:0] presc_sel_t;

    // one bus access is exactly one of these
    typedef enum logic [6:0] {
        ACC_NONE    = 7'h01,
        ACC_RAM     = 7'h02,
        ACC_PORT    = 7'h04,
        ACC_TMR_WR  = 7'h08,
        ACC_TMR_RD  = 7'h10,
        ACC_FLAG_RD = 7'h20,
        ACC_EDGE_WR = 7'h40
    } access_t;
endpackage : rio_pkg

// ===== timer_if.sv
// Purpose: carrier between the bus decoder and the interval timer
// Assumes: one clock domain, strobes last one cycle
// Notes:   load and read are never high together
`timescale 1ns/1ns
`default_nettype none
interface timer_if;
    logic                load;
    logic                read;
    rio_pkg::byte_t      data;
    rio_pkg::presc_sel_t presc_sel;
    rio_pkg::byte_t      count;
    logic                flag;

    modport ctrl  (output load, output read, output data, output presc_sel,
                   input count, input flag);
    modport timer (input load, input read, input data, input presc_sel,
                   output count, output flag);
endinterface : timer_if
`default_nettype wire

// ===== rio_ram.sv
// Purpose: byte-wide static scratch memory with registered read data
// Assumes: one write or read per clock, address stable at the edge
// Notes:   array is not cleared by reset, as in a real static ram
`timescale 1ns/1ns
`default_nettype none
`include "ram_io_timer_cfg.svh"
module rio_ram #(
    parameter int unsigned DEPTH = `RIO_RAM_DEPTH,
    parameter int unsigned AW    = `RIO_ADDR_W,
    parameter int unsigned DW    = `RIO_DATA_W
) (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          reset_n,
    // access
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [DW-1:0] wdata,
    output var  logic [DW-1:0] rdata_q
);
    logic [DW-1:0] mem [DEPTH];

    // storage, no reset so it maps onto a plain memory
    always_ff @(posedge clk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
    end

    // read data always from a flop
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= mem[addr];
        end
    end
endmodule : rio_ram
`default_nettype wire

// ===== rio_interval_timer.sv
// Purpose: eight bit down counter with prescaler and expiry flag
// Assumes: load and read are one-cycle strobes from the decoder
// Notes:   after expiry the counter runs at the full clock rate
`timescale 1ns/1ns
`default_nettype none
`include "ram_io_timer_cfg.svh"
module rio_interval_timer #(
    parameter int unsigned PRESC_W = `RIO_PRESC_W
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset_n,
    // decoder side
    timer_if.timer    tmr
);
    import rio_pkg::*;

    logic [PRESC_W-1:0] presc_q;
    logic [3:0]         shift_q;
    logic [PRESC_W-1:0] mask;
    logic               expired_q;
    logic               flag_q;
    byte_t              count_q;
    logic               tick;
    logic               set_flag;

    // one tick per prescaled interval, every clock once expired
    assign mask     = PRESC_W'((11'h1 << shift_q) - 11'h1);
    assign tick     = expired_q || ((presc_q & mask) == mask);
    assign set_flag = tick && (count_q == 8'h00) && !tmr.load;
    assign tmr.count = count_q;
    assign tmr.flag  = flag_q;

    // prescaler restarts with every load
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            presc_q <= '0;
            shift_q <= `RIO_PRESC_SH_1;
        end else if (tmr.load) begin
            presc_q <= '0;
            case (tmr.presc_sel)
                2'h0:    shift_q <= `RIO_PRESC_SH_1;
                2'h1:    shift_q <= `RIO_PRESC_SH_8;
                2'h2:    shift_q <= `RIO_PRESC_SH_64;
                default: shift_q <= `RIO_PRESC_SH_1024;
            endcase
        end else begin
            presc_q <= presc_q + 1'b1;
        end
    end

    // counting through zero wraps to all ones by itself
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= `RIO_TMR_CNT_RST;
        end else if (tmr.load) begin
            count_q <= tmr.data;
        end else if (tick) begin
            count_q <= count_q - 8'h01;
        end
    end

    // rate stays at one clock until the next load
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            expired_q <= 1'b0;
        end else if (tmr.load) begin
            expired_q <= 1'b0;
        end else if (set_flag) begin
            expired_q <= 1'b1;
        end
    end

    // set wins over a read in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_q <= 1'b0;
        end else if (set_flag) begin
            flag_q <= 1'b1;
        end else if (tmr.load || tmr.read) begin
            flag_q <= 1'b0;
        end
    end
endmodule : rio_interval_timer
`default_nettype wire

// ===== ram_io_timer_array.sv
// Purpose: processor-side ram, two eight bit ports, edge detect and timer
// Assumes: bus pins and port pins are synchronous to clk, one access per clk
// Notes:   read data appear one clock after the access is taken
`timescale 1ns/1ns
`default_nettype none
`include "ram_io_timer_cfg.svh"

// What this block does
// - 128 byte ram selected by chip selects
// - port A direction bit picks input or output
// - port A data read returns pin levels
// - output bits stored, driven once direction set
// - top line transition sets edge flag bit 6
// - enabled edge flag pulls interrupt low
// - edge control written by address, data ignored
// - edge flag sets regardless of direction or enable
// - reset disables edge interrupt, selects falling
// - flag register read clears edge flag
// - port B per bit direction and output
// - port B read returns output register
// - reset clears ports, bus drivers, interrupts
// - read high, drive bus only on reads
// - interrupt output active low, open drain
// - timer write loads count and prescale
// - address bit three sets timer interrupt enable
// - timer read shows remaining whole intervals
// - past zero, flag set, all ones, fast count
// - timer access clears flag; flag register layout
// - port registers versus timer by address bit two
// - timer write prescale versus edge control write
// - edge polarity and enable from address bits
module ram_io_timer_array #(
    parameter int unsigned ADDR_W = `RIO_ADDR_W
) (
    // clock and reset
    input  wire logic            clk,
    input  wire logic            reset_n,
    // processor bus
    input  wire logic            chip_select_high,
    input  wire logic            chip_select_low_n,
    input  wire logic            ram_io_select_n,
    input  wire logic            read_write,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire rio_pkg::byte_t  data_in,
    output var  rio_pkg::byte_t  data_out,
    output var  logic            data_oe,
    // port A pins
    input  wire rio_pkg::byte_t  port_a_lines_in,
    output var  rio_pkg::byte_t  port_a_lines_out,
    output var  rio_pkg::byte_t  port_a_lines_oe,
    // port B pins
    input  wire rio_pkg::byte_t  port_b_lines_in,
    output var  rio_pkg::byte_t  port_b_lines_out,
    output var  rio_pkg::byte_t  port_b_lines_oe,
    // open-drain interrupt request
    output var  logic            irq_n_out,
    output var  logic            irq_n_oe
);
    import rio_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    access_t acc;
    logic    selected;
    logic    is_read;
    logic    is_write;

    byte_t   port_a_direction_q;
    byte_t   port_a_output_q;
    byte_t   port_b_direction_q;
    byte_t   port_b_output_q;

    logic    edge_pol_q;       // 0 falling, 1 rising
    logic    edge_irq_en_q;
    logic    edge_flag_q;
    logic    top_line_prev_q;
    logic    port_a_top_line;
    logic    edge_hit;

    logic    timer_irq_en_q;
    logic    irq_q;

    byte_t   rdata_d;
    byte_t   rdata_q;
    logic    rd_valid_q;
    logic    rd_from_ram_q;
    byte_t   ram_rdata_q;
    logic    ram_we;

    timer_if tmr_bus ();

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------

    // the chip answers only with the high select up and the low select down
    assign selected = chip_select_high && !chip_select_low_n;
    assign is_read  = read_write;
    assign is_write = !read_write;

    // one access kind per clock; timer reads split on address bit zero
    always_comb begin
        if (!selected) begin
            acc = ACC_NONE;
        end else if (!ram_io_select_n) begin
            acc = ACC_RAM;
        end else if (!addr[`RIO_A_PORT_SEL]) begin
            acc = ACC_PORT;
        end else if (is_read && addr[`RIO_A_FLAG_SEL]) begin
            acc = ACC_FLAG_RD;
        end else if (is_read) begin
            acc = ACC_TMR_RD;
        end else if (addr[`RIO_A_TMR_WRITE]) begin
            acc = ACC_TMR_WR;
        end else begin
            acc = ACC_EDGE_WR;
        end
    end

    // ------------------------------------------------------------------
    // scratch ram
    // ------------------------------------------------------------------

    // all seven address lines pick the byte
    assign ram_we = (acc == ACC_RAM) && is_write;

    rio_ram #(
        .DEPTH (`RIO_RAM_DEPTH),
        .AW    (ADDR_W),
        .DW    (`RIO_DATA_W)
    ) u_ram (
        .clk     (clk),
        .reset_n (reset_n),
        .we      (ram_we),
        .addr    (addr),
        .wdata   (data_in),
        .rdata_q (ram_rdata_q)
    );

    // ------------------------------------------------------------------
    // port registers
    // ------------------------------------------------------------------

    // reset leaves every line an input with a zero output value
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            port_a_output_q    <= `RIO_PORT_RESET;
            port_a_direction_q <= `RIO_PORT_RESET;
            port_b_output_q    <= `RIO_PORT_RESET;
            port_b_direction_q <= `RIO_PORT_RESET;
        end else if ((acc == ACC_PORT) && is_write) begin
            case (addr[1:0])
                `RIO_PREG_OUT_A: port_a_output_q    <= data_in;
                `RIO_PREG_DIR_A: port_a_direction_q <= data_in;
                `RIO_PREG_OUT_B: port_b_output_q    <= data_in;
                default:         port_b_direction_q <= data_in;
            endcase
        end
    end

    // a stored output bit only reaches its pin once the line is an output
    assign port_a_lines_out = port_a_output_q;
    assign port_a_lines_oe  = port_a_direction_q;
    assign port_b_lines_out = port_b_output_q;
    assign port_b_lines_oe  = port_b_direction_q;

    // ------------------------------------------------------------------
    // edge detect on the top line of port A
    // ------------------------------------------------------------------

    // the pin level is watched whatever the direction, so an output line
    // toggled by software can trip the flag as well
    assign port_a_top_line = port_a_lines_in[7];

    // previous level; resets low so no spurious falling edge can be seen
    // in the first cycle, the rising edge is not active after reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            top_line_prev_q <= 1'b0;
        end else begin
            top_line_prev_q <= port_a_top_line;
        end
    end

    // polarity picks which transition counts
    assign edge_hit = edge_pol_q ? (port_a_top_line && !top_line_prev_q)
                                 : (!port_a_top_line && top_line_prev_q);

    // control comes from address bits; the data bus is ignored
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            edge_pol_q    <= `RIO_EDGE_POL_RST;
            edge_irq_en_q <= `RIO_EDGE_EN_RST;
        end else if (acc == ACC_EDGE_WR) begin
            edge_pol_q    <= addr[`RIO_A_EDGE_POL];
            edge_irq_en_q <= addr[`RIO_A_EDGE_EN];
        end
    end

    // flag sets even with the interrupt disabled; a new edge in the same
    // cycle as a flag register read is kept, so no event is lost
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            edge_flag_q <= 1'b0;
        end else if (edge_hit) begin
            edge_flag_q <= 1'b1;
        end else if (acc == ACC_FLAG_RD) begin
            edge_flag_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // interval timer
    // ------------------------------------------------------------------

    // strobes into the timer; prescale comes from the low address bits
    assign tmr_bus.load      = (acc == ACC_TMR_WR);
    assign tmr_bus.read      = (acc == ACC_TMR_RD);
    assign tmr_bus.data      = data_in;
    assign tmr_bus.presc_sel = addr[1:0];

    rio_interval_timer #(
        .PRESC_W (`RIO_PRESC_W)
    ) u_timer (
        .clk     (clk),
        .reset_n (reset_n),
        .tmr     (tmr_bus.timer)
    );

    // every timer read or write re-arms the interrupt enable from bit three;
    // software reads with it low after expiry to keep the line quiet
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_irq_en_q <= `RIO_TMR_EN_RST;
        end else if ((acc == ACC_TMR_WR) || (acc == ACC_TMR_RD)) begin
            timer_irq_en_q <= addr[`RIO_A_TMR_IRQ_EN];
        end
    end

    // ------------------------------------------------------------------
    // interrupt request
    // ------------------------------------------------------------------

    // registered so the pin never glitches on decode hazards
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (edge_flag_q && edge_irq_en_q)
                  || (tmr_bus.flag && timer_irq_en_q);
        end
    end

    // open drain: only ever pulls low, the pull-up lives off chip
    assign irq_n_out = 1'b0;
    assign irq_n_oe  = irq_q;

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------

    // read mux; port A shows the pins, port B shows its output register
    // because a heavily loaded B pin may not reach a clean logic level
    always_comb begin
        rdata_d = 8'h00;
        if (acc == ACC_PORT) begin
            case (addr[1:0])
                `RIO_PREG_OUT_A: rdata_d = port_a_lines_in;
                `RIO_PREG_DIR_A: rdata_d = port_a_direction_q;
                `RIO_PREG_OUT_B: rdata_d = port_b_output_q;
                default:         rdata_d = port_b_direction_q;
            endcase
        end else if (acc == ACC_TMR_RD) begin
            rdata_d = tmr_bus.count;
        end else if (acc == ACC_FLAG_RD) begin
            rdata_d[`RIO_FLAG_TIMER_BIT] = tmr_bus.flag;
            rdata_d[`RIO_FLAG_EDGE_BIT]  = edge_flag_q;
            rdata_d[5:0] = `RIO_FLAG_LOW_ZERO;
        end
    end

    // capture read data and the drive window; values are those before any
    // clear caused by the same read
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdata_q       <= 8'h00;
            rd_valid_q    <= 1'b0;
            rd_from_ram_q <= 1'b0;
        end else begin
            rdata_q       <= rdata_d;
            rd_valid_q    <= (acc != ACC_NONE) && is_read;
            rd_from_ram_q <= (acc == ACC_RAM) && is_read;
        end
    end

    // both sources are flops; the bus is driven for one clock per read
    assign data_out = rd_from_ram_q ? ram_rdata_q : rdata_q;
    assign data_oe  = rd_valid_q;

endmodule : ram_io_timer_array
`default_nettype wire

// ===== port_peer.sv
// Purpose: peripheral side of both ports and the pulled-up request line
// Assumes: device enables win over the peripheral drive on any bit
// Notes:   undriven lines read high through their pull-ups
`timescale 1ns/1ns
`default_nettype none
module port_peer (
    // device pins
    input  wire rio_pkg::byte_t a_out,
    input  wire rio_pkg::byte_t a_oe,
    input  wire rio_pkg::byte_t b_out,
    input  wire rio_pkg::byte_t b_oe,
    input  wire logic           irq_out,
    input  wire logic           irq_oe,
    // peripheral drive
    input  wire rio_pkg::byte_t a_drv,
    input  wire rio_pkg::byte_t a_en,
    input  wire rio_pkg::byte_t b_drv,
    input  wire rio_pkg::byte_t b_en,
    // resolved wires
    output var  rio_pkg::byte_t a_pins,
    output var  rio_pkg::byte_t b_pins,
    output var  logic           irq_line
);
    // a line nobody drives floats up to one, never to a stale value
    always_comb begin
        a_pins   = (a_oe & a_out) | (~a_oe & a_en & a_drv) | (~a_oe & ~a_en);
        b_pins   = (b_oe & b_out) | (~b_oe & b_en & b_drv) | (~b_oe & ~b_en);
        irq_line = irq_oe ? irq_out : 1'b1;
    end
endmodule : port_peer
`default_nettype wire

// ===== ram_io_timer_array_assertions.sv
// Purpose: bus and port timing checks for the ram, port and timer block
// Assumes: one clock domain, sees only the top module ports
// Notes:   reset values are checked at the first edge after release
`timescale 1ns/1ns
`default_nettype none
module rio_checker
    import rio_pkg::*;
#(
    parameter int unsigned ADDR_W = 7
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // processor bus
    input  wire logic              chip_select_high,
    input  wire logic              chip_select_low_n,
    input  wire logic              ram_io_select_n,
    input  wire logic              read_write,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire rio_pkg::byte_t    data_in,
    input  wire rio_pkg::byte_t    data_out,
    input  wire logic              data_oe,
    // ports and request
    input  wire rio_pkg::byte_t    port_a_lines_in,
    input  wire rio_pkg::byte_t    port_a_lines_out,
    input  wire rio_pkg::byte_t    port_a_lines_oe,
    input  wire rio_pkg::byte_t    port_b_lines_in,
    input  wire rio_pkg::byte_t    port_b_lines_out,
    input  wire rio_pkg::byte_t    port_b_lines_oe,
    input  wire logic              irq_n_out,
    input  wire logic              irq_n_oe
);
    logic sel;
    logic rd;
    logic io;
    // decoded strobes, kept combinational so they match the taking edge
    assign sel = chip_select_high && !chip_select_low_n;
    assign rd  = sel && read_write;
    assign io  = sel && ram_io_select_n;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    property p_rd_oe; rd |-> ##1 data_oe; endproperty
    a_rd_oe: assert property (p_rd_oe) else $error("read not answered");
    property p_oe_only; data_oe |-> $past(rd); endproperty
    a_oe_only: assert property (p_oe_only) else $error("bus driven unasked");
    property p_rst;
        $rose(reset_n) |-> !data_oe && !irq_n_oe && port_a_lines_oe == 8'h00
            && port_b_lines_oe == 8'h00 && port_a_lines_out == 8'h00
            && port_b_lines_out == 8'h00;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    property p_dir_a; io && !read_write && addr[2:0] == 3'h1
        |=> port_a_lines_oe == $past(data_in); endproperty
    a_dir_a: assert property (p_dir_a) else $error("dir a not loaded");
    property p_out_b; io && !read_write && addr[2:0] == 3'h2
        |=> port_b_lines_out == $past(data_in); endproperty
    a_out_b: assert property (p_out_b) else $error("out b not loaded");
    property p_pa_rd; io && read_write && addr[2:0] == 3'h0
        |=> data_out == $past(port_a_lines_in); endproperty
    a_pa_rd: assert property (p_pa_rd) else $error("port a read not pins");
    property p_pb_rd; io && read_write && addr[2:0] == 3'h2
        |=> data_out == port_b_lines_out; endproperty
    a_pb_rd: assert property (p_pb_rd) else $error("port b read wrong");
    property p_flag; io && read_write && addr[2] && addr[0]
        |=> data_out[5:0] == 6'h00; endproperty
    a_flag: assert property (p_flag) else $error("flag low bits set");
    property p_od; irq_n_out == 1'b0; endproperty
    a_od: assert property (p_od) else $error("request drives high");

    c_read: cover property (rd ##1 data_oe);
    c_irq: cover property ($rose(irq_n_oe));
    c_irq_off: cover property ($fell(irq_n_oe));
endmodule : rio_checker
`default_nettype wire

bind ram_io_timer_array rio_checker #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .reset_n(reset_n),
    .chip_select_high(chip_select_high), .chip_select_low_n(chip_select_low_n),
    .ram_io_select_n(ram_io_select_n), .read_write(read_write), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .port_a_lines_in(port_a_lines_in), .port_a_lines_out(port_a_lines_out),
    .port_a_lines_oe(port_a_lines_oe), .port_b_lines_in(port_b_lines_in),
    .port_b_lines_out(port_b_lines_out), .port_b_lines_oe(port_b_lines_oe),
    .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

// ===== tb_ram_io_timer_array.sv
// Purpose: self-checking bench for the ram, port and timer block
// Assumes: bus requests held over one taking edge, released after it
// Notes:   peripheral lines resolved by the port_peer model
`timescale 1ns/1ns
`default_nettype none
module tb_ram_io_timer_array;
    import rio_pkg::*;
    logic        clk, reset_n, chs, csn, rsn, rw, doe, irq_o, irq_oe, irq_line;
    logic [6:0]  addr;
    byte_t       din, dout, pa_o, pa_oe, pb_o, pb_oe, pa_pins, pb_pins;
    byte_t       a_drv, a_en, b_drv, b_en;
    int          mismatches, num_checks, cycles;

    ram_io_timer_array dut (.clk(clk), .reset_n(reset_n), .chip_select_high(chs),
        .chip_select_low_n(csn), .ram_io_select_n(rsn), .read_write(rw), .addr(addr),
        .data_in(din), .data_out(dout), .data_oe(doe), .port_a_lines_in(pa_pins),
        .port_a_lines_out(pa_o), .port_a_lines_oe(pa_oe), .port_b_lines_in(pb_pins),
        .port_b_lines_out(pb_o), .port_b_lines_oe(pb_oe), .irq_n_out(irq_o),
        .irq_n_oe(irq_oe));
    port_peer peer (.a_out(pa_o), .a_oe(pa_oe), .b_out(pb_o), .b_oe(pb_oe),
        .irq_out(irq_o), .irq_oe(irq_oe), .a_drv(a_drv), .a_en(a_en), .b_drv(b_drv),
        .b_en(b_en), .a_pins(pa_pins), .b_pins(pb_pins), .irq_line(irq_line));

    // free running clock, 8 ns period
    always #4 clk = ~clk;

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out

    task automatic wr(input logic [6:0] a, input byte_t d, input logic io);
        chs <= 1'b1; rw <= 1'b0; rsn <= io; addr <= a; din <= d;
        @(posedge clk);
        chs <= 1'b0;
        @(posedge clk);
    endtask : wr

    // read data is only trusted while the bus drivers are on
    task automatic rd(input logic [6:0] a, input logic io, output byte_t v);
        chs <= 1'b1; rw <= 1'b1; rsn <= io; addr <= a;
        @(posedge clk);
        chs <= 1'b0;
        #1 v = (doe === 1'b1) ? dout : 8'hXX;
        @(posedge clk);
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    task automatic t_reset;
        byte_t v;
        rd(7'h01, 1, v); check(v, 8'h00);
        rd(7'h03, 1, v); check(v, 8'h00);
        rd(7'h02, 1, v); check(v, 8'h00);
        rd(7'h00, 1, v); check(v, 8'hFF);
        a_en <= 8'hFF;
        settle(3); check(irq_line, 1'b1);
        wr(7'h17, 8'hFF, 1);
        rd(7'h05, 1, v); check(v, 8'h40);
        $display("reset test done");
    endtask : t_reset

    task automatic t_ram;
        byte_t v;
        wr(7'h00, 8'h3C, 0); wr(7'h7F, 8'hC3, 0);
        csn <= 1'b1; wr(7'h00, 8'hAA, 0); csn <= 1'b0;
        rd(7'h00, 0, v); check(v, 8'h3C);
        rd(7'h7F, 0, v); check(v, 8'hC3);
        $display("ram test done");
    endtask : t_ram

    task automatic t_ports;
        byte_t v;
        a_drv <= 8'h5A; a_en <= 8'hF0; b_drv <= 8'h33; b_en <= 8'hF0;
        wr(7'h00, 8'hF0, 1); rd(7'h00, 1, v); check(v, 8'h5F);
        wr(7'h01, 8'h0F, 1); rd(7'h00, 1, v); check(v, 8'h50);
        wr(7'h02, 8'hC5, 1); wr(7'h03, 8'h0F, 1);
        rd(7'h02, 1, v); check(v, 8'hC5);
        rd(7'h03, 1, v); check(v, 8'h0F);
        check(pb_pins, 8'h35);
        $display("port test done");
    endtask : t_ports

    task automatic t_edge;
        byte_t v;
        wr(7'h06, 8'hA5, 1); rd(7'h05, 1, v);
        a_drv <= 8'hDA; settle(3); check(irq_line, 1'b1);
        a_drv <= 8'h5A; settle(3); check(irq_line, 1'b0);
        rd(7'h05, 1, v); check(v, 8'h40);
        rd(7'h05, 1, v); check(v, 8'h00);
        settle(1); check(irq_line, 1'b1);
        wr(7'h05, 8'h00, 1); rd(7'h05, 1, v);
        a_drv <= 8'hDA; settle(3); check(irq_line, 1'b1);
        rd(7'h05, 1, v); check(v, 8'h40);
        a_en <= 8'h70; wr(7'h01, 8'h8F, 1); wr(7'h00, 8'h70, 1); rd(7'h05, 1, v);
        wr(7'h00, 8'hF0, 1); settle(2);
        rd(7'h05, 1, v); check(v, 8'h40);
        $display("edge test done");
    endtask : t_edge

    // each prescale once, count of one, interrupt enabled through A3
    task automatic t_timer;
        byte_t v;
        int    n, dv;
        for (int k = 0; k < 4; k++) begin
            dv = (k == 3) ? 1024 : (1 << (3 * k));
            wr(7'h1C | 7'(k), 8'h01, 1);
            n = 1;
            if (k > 0) begin
                rd(7'h0C, 1, v); check(v, 8'h01);
                n = 3;
            end
            while (irq_line !== 1'b0 && n < 3000) begin
                settle(1);
                n++;
            end
            check(16'(n), 16'(2 * dv + 1));
            rd(7'h05, 1, v); check(v, 8'h80);
            rd(7'h04, 1, v); check(v[7:4], 4'hF);
            settle(1); check(irq_line, 1'b1);
        end
        rd(7'h05, 1, v); check(v, 8'h00);
        $display("timer test done");
    endtask : t_timer

    // hang guard, well above the longest expected run
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 8000) begin
            mismatches++;
            close_out;
        end
    end

    initial begin
        clk = 0; reset_n = 0; chs = 0; csn = 0; rsn = 0; rw = 1; addr = 0; din = 0;
        a_drv = 0; a_en = 0; b_drv = 0; b_en = 0; mismatches = 0; num_checks = 0;
        cycles = 0;
        repeat (8) @(posedge clk);
        check(byte_t'(doe), 8'h00);
        reset_n <= 1'b1;
        @(posedge clk);
        t_reset;
        t_ram;
        t_ports;
        t_edge;
        t_timer;
        close_out;
    end
endmodule : tb_ram_io_timer_array
`default_nettype wire
